/* include/i2c_irq_pkg.sv */
package i2c_irq_pkg;
	// Flag positions in the software clear vector
	localparam int FLAG_W          = 6;
	localparam int IDX_TX_EMPTY    = 0;
	localparam int IDX_TX_END      = 1;
	localparam int IDX_RX_FULL     = 2;
	localparam int IDX_STOP_SEEN   = 3;
	localparam int IDX_NO_ACK      = 4;
	localparam int IDX_ARB_OVERRUN = 5;

	// Values after reset
	localparam logic       TX_EMPTY_RST = 1'b0;
	localparam logic [7:0] DATA_RST     = 8'h00;

	// SCL monitoring time in half system clock cycles, as printed
	localparam int MON_HALF_00 = 15;
	localparam int MON_HALF_01 = 39;
	localparam int MON_HALF_10 = 35;
	localparam int MON_HALF_11 = 83;
	// Least time, so round up to whole cycles
	localparam int MON_CYC_00  = (MON_HALF_00 + 1) / 2;
	localparam int MON_CYC_01  = (MON_HALF_01 + 1) / 2;
	localparam int MON_CYC_10  = (MON_HALF_10 + 1) / 2;
	localparam int MON_CYC_11  = (MON_HALF_11 + 1) / 2;
	localparam int MON_CNT_W   = 6;

	// Input synchroniser depth
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_MONITOR,
		SYNC_WAIT_HIGH
	} scl_sync_state_t;
endpackage

/* rtl/scl_bit_sync.sv */
`timescale 1ns/1ps
module scl_bit_sync (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_enable,
	input  wire logic       i_release,
	input  wire logic       i_scl_in,
	input  wire logic [1:0] i_cks_hi,
	output logic            o_scl_level,
	output logic            o_high_ok,
	output logic            o_stretching
);
	logic [i2c_irq_pkg::SYNC_STAGES-1:0]  sync_r;
	logic                                 level_r;
	logic [i2c_irq_pkg::MON_CNT_W-1:0]    cnt_r;
	logic [i2c_irq_pkg::MON_CNT_W-1:0]    mon_len;
	logic                                 agree;
	logic                                 release_d_r;
	logic                                 release_rise;
	i2c_irq_pkg::scl_sync_state_t         state_r;
	i2c_irq_pkg::scl_sync_state_t         state_nxt;

	// Pin sampled by three flops; level follows only when last two agree
	assign agree        = sync_r[1] == sync_r[2];
	assign release_rise = i_release & ~release_d_r;

	assign mon_len = (i_cks_hi == 2'b00) ? i2c_irq_pkg::MON_CNT_W'(i2c_irq_pkg::MON_CYC_00) :
	                 (i_cks_hi == 2'b01) ? i2c_irq_pkg::MON_CNT_W'(i2c_irq_pkg::MON_CYC_01) :
	                 (i_cks_hi == 2'b10) ? i2c_irq_pkg::MON_CNT_W'(i2c_irq_pkg::MON_CYC_10) :
	                                       i2c_irq_pkg::MON_CNT_W'(i2c_irq_pkg::MON_CYC_11);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			sync_r      <= '1;
			level_r     <= 1'b1;
			release_d_r <= 1'b0;
		end else begin
			sync_r      <= {sync_r[1:0], i_scl_in};
			release_d_r <= i_release;
			if (agree)
				level_r <= sync_r[2];
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			i2c_irq_pkg::SYNC_IDLE: begin
				if (i_enable && release_rise)
					state_nxt = i2c_irq_pkg::SYNC_MONITOR;
			end
			i2c_irq_pkg::SYNC_MONITOR: begin
				if (!i_release || !i_enable)
					state_nxt = i2c_irq_pkg::SYNC_IDLE;
				else if (cnt_r >= mon_len - 1'b1)
					state_nxt = i2c_irq_pkg::SYNC_WAIT_HIGH;
			end
			i2c_irq_pkg::SYNC_WAIT_HIGH: begin
				// Slave hold or slow rise keeps us here
				if (!i_release || !i_enable || level_r)
					state_nxt = i2c_irq_pkg::SYNC_IDLE;
			end
			default: state_nxt = i2c_irq_pkg::SYNC_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= i2c_irq_pkg::SYNC_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_r == i2c_irq_pkg::SYNC_MONITOR)
				cnt_r <= cnt_r + 1'b1;
			else
				cnt_r <= '0;
		end
	end

	assign o_scl_level  = level_r;
	// High phase starts only once SCL is seen high after the wait
	assign o_high_ok    = (state_r == i2c_irq_pkg::SYNC_WAIT_HIGH) & level_r
	                      & i_release & i_enable;
	// Gated like the high phase, so a re-grabbed line never reads as a stretch
	assign o_stretching = (state_r == i2c_irq_pkg::SYNC_WAIT_HIGH) & ~level_r
	                      & i_release & i_enable;
endmodule

/* rtl/i2c_irq_sync.sv */
// What this block does
// - Tx-empty, tx-end, rx-full requests are flag AND enable, both modes.
// - Stop request is flag AND enable, only in I2C mode.
// - Shared request: enable AND (no-ack in I2C, or arb-lost/overrun).
// - Writing transmit data clears tx-end flag, and tx-empty unless shift stage is idle.
// - Reading receive data clears the rx-full flag.
// - Tx-empty sets again when written data moves on to shift stage.
// - Master watches real SCL level after release before high phase.
// - Clock phase extends while SCL held low or rising slowly.
// - Monitor time from clock-select bits: 8, 20, 18, 42 cycles (7.5, 19.5, 17.5, 41.5 rounded up).
// - Format-select 1 selects clocked synchronous format instead of I2C.
// - Sync receive: eighth rise with rx-full set flags overrun, keeps byte.
`timescale 1ns/1ps
module i2c_irq_sync (
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst,
	input  wire logic                           i_format_select,
	input  wire logic                           i_master_mode,
	input  wire logic                           i_clock_select_bit3,
	input  wire logic                           i_clock_select_bit2,
	input  wire logic                           i_tx_empty_irq_enable,
	input  wire logic                           i_tx_end_irq_enable,
	input  wire logic                           i_rx_full_irq_enable,
	input  wire logic                           i_stop_seen_irq_enable,
	input  wire logic                           i_no_ack_irq_enable,
	input  wire logic                           i_tx_data_write,
	input  wire logic [7:0]                     i_tx_data,
	input  wire logic                           i_rx_data_read,
	input  wire logic                           i_tx_mode_enter,
	input  wire logic                           i_shift_idle,
	input  wire logic                           i_shift_load,
	input  wire logic                           i_tx_end_event,
	input  wire logic                           i_rx_byte_done,
	input  wire logic [7:0]                     i_rx_shift_data,
	input  wire logic                           i_eighth_rise,
	input  wire logic                           i_stop_event,
	input  wire logic                           i_no_ack_event,
	input  wire logic                           i_arb_lost_event,
	input  wire logic [i2c_irq_pkg::FLAG_W-1:0] i_flag_clear,
	input  wire logic                           i_scl_drive_low,
	input  wire logic                           i_scl_in,
	output logic                                o_scl_out,
	output logic                                o_scl_oe,
	output logic                                o_scl_level,
	output logic                                o_scl_high_ok,
	output logic                                o_scl_stretching,
	output logic [7:0]                          o_tx_data_register,
	output logic [7:0]                          o_rx_data_register,
	output logic                                o_tx_empty_flag,
	output logic                                o_tx_end_flag,
	output logic                                o_rx_full_flag,
	output logic                                o_stop_seen_flag,
	output logic                                o_no_ack_flag,
	output logic                                o_arb_lost_overrun_flag,
	output logic                                o_tx_empty_request,
	output logic                                o_tx_end_request,
	output logic                                o_rx_full_request,
	output logic                                o_stop_seen_request,
	output logic                                o_no_ack_request
);
	logic       tx_empty_r;
	logic       tx_end_r;
	logic       rx_full_r;
	logic       stop_seen_r;
	logic       no_ack_r;
	logic       arb_ovr_r;
	logic       tx_empty_nxt;
	logic       tx_end_nxt;
	logic       rx_full_nxt;
	logic       stop_seen_nxt;
	logic       no_ack_nxt;
	logic       arb_ovr_nxt;
	logic [7:0] tx_data_r;
	logic [7:0] rx_data_r;
	logic       i2c_mode;
	logic       sync_mode;
	logic       overrun;
	logic       rx_take;
	logic       tx_empty_set;
	logic       tx_empty_clr;
	logic       scl_release;

	assign sync_mode = i_format_select;
	assign i2c_mode  = ~i_format_select;

	// Receive while the old byte is unread in sync mode loses the new one
	assign overrun = sync_mode & i_eighth_rise & rx_full_r;
	assign rx_take = i_rx_byte_done & ~(sync_mode & rx_full_r);

	// A write straight into an idle shift stage leaves the buffer empty
	assign tx_empty_set = i_tx_mode_enter | i_shift_load
	                      | (i_tx_data_write & i_shift_idle);
	assign tx_empty_clr = i_tx_data_write | i_flag_clear[i2c_irq_pkg::IDX_TX_EMPTY];

	// Set beats clear on every flag, so no event is dropped
	assign tx_empty_nxt  = tx_empty_set | (tx_empty_r & ~tx_empty_clr);
	assign tx_end_nxt    = i_tx_end_event
	                       | (tx_end_r & ~i_tx_data_write
	                          & ~i_flag_clear[i2c_irq_pkg::IDX_TX_END]);
	assign rx_full_nxt   = rx_take
	                       | (rx_full_r & ~i_rx_data_read
	                          & ~i_flag_clear[i2c_irq_pkg::IDX_RX_FULL]);
	assign stop_seen_nxt = (i2c_mode & i_stop_event)
	                       | (stop_seen_r & ~i_flag_clear[i2c_irq_pkg::IDX_STOP_SEEN]);
	assign no_ack_nxt    = (i2c_mode & i_no_ack_event)
	                       | (no_ack_r & ~i_flag_clear[i2c_irq_pkg::IDX_NO_ACK]);
	assign arb_ovr_nxt   = (i2c_mode & i_arb_lost_event) | overrun
	                       | (arb_ovr_r & ~i_flag_clear[i2c_irq_pkg::IDX_ARB_OVERRUN]);

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tx_empty_r  <= i2c_irq_pkg::TX_EMPTY_RST;
			tx_end_r    <= 1'b0;
			rx_full_r   <= 1'b0;
			stop_seen_r <= 1'b0;
			no_ack_r    <= 1'b0;
			arb_ovr_r   <= 1'b0;
		end else begin
			tx_empty_r  <= tx_empty_nxt;
			tx_end_r    <= tx_end_nxt;
			rx_full_r   <= rx_full_nxt;
			stop_seen_r <= stop_seen_nxt;
			no_ack_r    <= no_ack_nxt;
			arb_ovr_r   <= arb_ovr_nxt;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tx_data_r <= i2c_irq_pkg::DATA_RST;
			rx_data_r <= i2c_irq_pkg::DATA_RST;
		end else begin
			if (i_tx_data_write)
				tx_data_r <= i_tx_data;
			if (rx_take)
				rx_data_r <= i_rx_shift_data;
		end
	end

	assign o_tx_data_register      = tx_data_r;
	assign o_rx_data_register      = rx_data_r;
	assign o_tx_empty_flag         = tx_empty_r;
	assign o_tx_end_flag           = tx_end_r;
	assign o_rx_full_flag          = rx_full_r;
	assign o_stop_seen_flag        = stop_seen_r;
	assign o_no_ack_flag           = no_ack_r;
	assign o_arb_lost_overrun_flag = arb_ovr_r;

	// Levels straight from flag registers, so they drop one edge after a clear
	assign o_tx_empty_request  = tx_empty_r & i_tx_empty_irq_enable;
	assign o_tx_end_request    = tx_end_r & i_tx_end_irq_enable;
	assign o_rx_full_request   = rx_full_r & i_rx_full_irq_enable;
	assign o_stop_seen_request = i2c_mode & stop_seen_r & i_stop_seen_irq_enable;
	assign o_no_ack_request    = i_no_ack_irq_enable
	                             & ((i2c_mode & no_ack_r) | arb_ovr_r);

	// Open-drain SCL: only ever pulled low, released otherwise
	assign o_scl_out   = 1'b0;
	assign o_scl_oe    = i_master_mode & i_scl_drive_low;
	assign scl_release = i_master_mode & ~i_scl_drive_low;

	scl_bit_sync u_scl_sync (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_enable     (i_master_mode),
		.i_release    (scl_release),
		.i_scl_in     (i_scl_in),
		.i_cks_hi     ({i_clock_select_bit3, i_clock_select_bit2}),
		.o_scl_level  (o_scl_level),
		.o_high_ok    (o_scl_high_ok),
		.o_stretching (o_scl_stretching)
	);
endmodule

/* testbench/i2c_irq_sync_assertions.sv */
`timescale 1ns/1ps
module i2c_irq_sync_assertions (
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic       i_format_select,
	input wire logic       i_master_mode,
	input wire logic       i_scl_drive_low,
	input wire logic       i_clock_select_bit3,
	input wire logic       i_clock_select_bit2,
	input wire logic       i_tx_empty_irq_enable,
	input wire logic       i_tx_end_irq_enable,
	input wire logic       i_rx_full_irq_enable,
	input wire logic       i_stop_seen_irq_enable,
	input wire logic       i_no_ack_irq_enable,
	input wire logic       i_tx_data_write,
	input wire logic       i_rx_data_read,
	input wire logic       i_shift_idle,
	input wire logic       i_tx_mode_enter,
	input wire logic       i_shift_load,
	input wire logic       i_tx_end_event,
	input wire logic       i_rx_byte_done,
	input wire logic       i_eighth_rise,
	input wire logic       o_scl_level,
	input wire logic       o_scl_high_ok,
	input wire logic       o_scl_stretching,
	input wire logic       o_tx_empty_flag,
	input wire logic       o_tx_end_flag,
	input wire logic       o_rx_full_flag,
	input wire logic       o_stop_seen_flag,
	input wire logic       o_no_ack_flag,
	input wire logic       o_arb_lost_overrun_flag,
	input wire logic       o_tx_empty_request,
	input wire logic       o_tx_end_request,
	input wire logic       o_rx_full_request,
	input wire logic       o_stop_seen_request,
	input wire logic       o_no_ack_request,
	input wire logic [7:0] o_rx_data_register
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	wire       rel   = i_master_mode & ~i_scl_drive_low;
	wire [1:0] cks   = {i_clock_select_bit3, i_clock_select_bit2};
	wire [6:0] mon_w = (cks == 2'h0) ? 7'h08 : (cks == 2'h1) ? 7'h14 :
	                   (cks == 2'h2) ? 7'h12 : 7'h2a;
	logic [6:0] rel_cnt_r;
	// Cycles since release, saturating so long stretches never wrap
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			rel_cnt_r <= 7'h00;
		else if (!rel)
			rel_cnt_r <= 7'h00;
		else if (rel_cnt_r != 7'h7f)
			rel_cnt_r <= rel_cnt_r + 7'h01;
	end
	sequence tx_write_only;
		i_tx_data_write && !i_shift_idle && !i_shift_load && !i_tx_mode_enter && !i_tx_end_event;
	endsequence
	sequence overrun_hit;
		i_format_select && o_rx_full_flag && i_eighth_rise;
	endsequence
	AST_BASIC_REQ: assert property (o_tx_empty_request == (o_tx_empty_flag & i_tx_empty_irq_enable)
		&& o_tx_end_request == (o_tx_end_flag & i_tx_end_irq_enable)
		&& o_rx_full_request == (o_rx_full_flag & i_rx_full_irq_enable))
		else $error("basic request mismatch");
	AST_STOP_REQ: assert property (o_stop_seen_request ==
		(o_stop_seen_flag & i_stop_seen_irq_enable & ~i_format_select))
		else $error("stop request mismatch");
	AST_SHARED_REQ: assert property (o_no_ack_request == (i_no_ack_irq_enable &
		((o_no_ack_flag & ~i_format_select) | o_arb_lost_overrun_flag)))
		else $error("shared request mismatch");
	AST_WRITE_CLEARS: assert property (tx_write_only |=>
		!o_tx_empty_flag && !o_tx_end_flag && !o_tx_empty_request)
		else $error("write did not clear transmit flags");
	AST_READ_CLEARS: assert property (i_rx_data_read && !i_rx_byte_done |=> !o_rx_full_flag)
		else $error("read did not clear receive flag");
	AST_EMPTY_SETS: assert property (i_shift_load || (i_tx_data_write && i_shift_idle) |=>
		o_tx_empty_flag) else $error("transmit empty not set on load");
	AST_OVERRUN: assert property (overrun_hit |=>
		o_arb_lost_overrun_flag && $stable(o_rx_data_register))
		else $error("overrun not flagged or byte lost");
	AST_HIGH_OK: assert property (o_scl_high_ok |-> o_scl_level && rel && rel_cnt_r >= mon_w)
		else $error("high phase accepted too early");
	AST_STRETCH: assert property (o_scl_stretching |-> !o_scl_level && rel && rel_cnt_r >= mon_w)
		else $error("stretch flag without low line");
endmodule
bind i2c_irq_sync i2c_irq_sync_assertions u_i2c_irq_sync_assertions (.*);

/* testbench/scl_far_device.sv */
`timescale 1ns/1ps
module scl_far_device (
	input  wire logic       i_scl_oe,
	input  wire logic [3:0] i_stretch,
	output logic            o_scl
);
	logic hold_r;
	initial hold_r = 1'b0;
	// Slave keeps SCL low after master release, in 160 ns link ticks
	always @(negedge i_scl_oe) begin
		if (i_stretch != 4'h0) begin
			hold_r = 1'b1;
			#(160 * i_stretch);
			hold_r = 1'b0;
		end
	end
	// Pull-up with bus load: slow edge
	assign #20 o_scl = !(i_scl_oe || hold_r);
endmodule

/* testbench/i2c_irq_sync_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module i2c_irq_sync_tb;
	logic       i_mclk, i_rst, i_format_select, i_master_mode, i_clock_select_bit3;
	logic       i_clock_select_bit2, i_tx_empty_irq_enable, i_tx_end_irq_enable;
	logic       i_rx_full_irq_enable, i_stop_seen_irq_enable, i_no_ack_irq_enable;
	logic       i_tx_data_write, i_rx_data_read, i_tx_mode_enter, i_shift_idle, i_shift_load;
	logic       i_tx_end_event, i_rx_byte_done, i_eighth_rise, i_stop_event, i_no_ack_event;
	logic       i_arb_lost_event, i_scl_drive_low, o_scl_out, o_scl_oe, o_scl_level;
	logic       o_scl_high_ok, o_scl_stretching, o_tx_empty_flag, o_tx_end_flag, o_rx_full_flag;
	logic       o_stop_seen_flag, o_no_ack_flag, o_arb_lost_overrun_flag, o_tx_empty_request;
	logic       o_tx_end_request, o_rx_full_request, o_stop_seen_request, o_no_ack_request;
	logic       en, seen;
	logic [7:0] i_tx_data, i_rx_shift_data, o_tx_data_register, o_rx_data_register, d;
	logic [5:0] i_flag_clear;
	logic [3:0] stretch;
	wire        i_scl_in;
	int         seed, err_count, total_checks, cycles, k, n;
	i2c_irq_sync u_i2c_irq_sync (.*);
	scl_far_device u_scl_far_device (.i_scl_oe(o_scl_oe), .i_stretch(stretch), .o_scl(i_scl_in));
	function automatic int exp_mon(input logic [1:0] c);
		return (c == 2'h0) ? i2c_irq_pkg::MON_CYC_00 : (c == 2'h1) ? i2c_irq_pkg::MON_CYC_01 :
			(c == 2'h2) ? i2c_irq_pkg::MON_CYC_10 : i2c_irq_pkg::MON_CYC_11;
	endfunction
	typedef enum int {MODE_ENTER, TX_END_EV, TX_WRITE, SHIFT_LOAD, RX_DONE, EIGHTH_RISE,
		RX_READ, STOP_EV, NO_ACK_EV, ARB_EV} pulse_t;
	// Strobes picked by name, so no reference argument is driven late
	task automatic set_pulse(input pulse_t p, input logic v);
		case (p)
			MODE_ENTER:  i_tx_mode_enter <= v;
			TX_END_EV:   i_tx_end_event <= v;
			TX_WRITE:    i_tx_data_write <= v;
			SHIFT_LOAD:  i_shift_load <= v;
			RX_DONE:     i_rx_byte_done <= v;
			EIGHTH_RISE: i_eighth_rise <= v;
			RX_READ:     i_rx_data_read <= v;
			STOP_EV:     i_stop_event <= v;
			NO_ACK_EV:   i_no_ack_event <= v;
			default:     i_arb_lost_event <= v;
		endcase
	endtask
	task automatic pulse(input pulse_t p);
		@(posedge i_mclk) set_pulse(p, 1'b1);
		@(posedge i_mclk) set_pulse(p, 1'b0);
		#1;
	endtask
	task automatic clr(input logic [5:0] m);
		@(posedge i_mclk) i_flag_clear <= m;
		@(posedge i_mclk) i_flag_clear <= 6'h00;
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		seed = 8187;
		stretch = 4'h0;
		i_rst = 1'b1;
		{i_format_select, i_master_mode, i_clock_select_bit3, i_clock_select_bit2,
			i_tx_empty_irq_enable, i_tx_end_irq_enable, i_rx_full_irq_enable,
			i_stop_seen_irq_enable, i_no_ack_irq_enable, i_tx_data_write, i_rx_data_read,
			i_tx_mode_enter, i_shift_idle, i_shift_load, i_tx_end_event, i_rx_byte_done,
			i_eighth_rise, i_stop_event, i_no_ack_event, i_arb_lost_event, i_scl_drive_low,
			i_tx_data, i_rx_shift_data, i_flag_clear} = '0;
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		#1 `CHK({o_scl_level, o_tx_empty_flag, o_rx_full_flag}, 3'h4)
		for (k = 0; k < 20; k++) begin
			en = 1'($random(seed));
			d = 8'($random(seed));
			i_tx_empty_irq_enable <= en;
			i_tx_end_irq_enable <= en;
			i_tx_data <= d;
			pulse(MODE_ENTER);
			pulse(TX_END_EV);
			`CHK({o_tx_empty_request, o_tx_end_request}, {en, en})
			pulse(TX_WRITE);
			`CHK({o_tx_empty_flag, o_tx_end_flag, o_tx_data_register}, {2'h0, d})
			pulse(SHIFT_LOAD);
			`CHK({o_tx_empty_flag, o_tx_empty_request}, {1'b1, en})
		end
		// Free shift stage: a write goes straight through
		i_shift_idle <= 1'b1;
		pulse(TX_WRITE);
		`CHK(o_tx_empty_flag, 1'b1)
		i_shift_idle <= 1'b0;
		$display("transmit test done");
		i_rx_full_irq_enable <= 1'b1;
		for (k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			i_format_select <= k[0];
			i_rx_shift_data <= d;
			pulse(RX_DONE);
			`CHK({o_rx_full_flag, o_rx_full_request}, 2'h3)
			i_rx_shift_data <= ~d;
			pulse(EIGHTH_RISE);
			pulse(RX_DONE);
			`CHK(o_rx_data_register, k[0] ? d : ~d)
			`CHK(o_arb_lost_overrun_flag, k[0])
			pulse(RX_READ);
			`CHK(o_rx_full_flag, 1'b0)
		end
		$display("receive test done");
		// Acting as the unmasked CPU: service, then clear sources in the handler
		i_stop_seen_irq_enable <= 1'b1;
		i_no_ack_irq_enable <= 1'b1;
		@(posedge i_mclk) #1 `CHK(o_no_ack_request, 1'b1)
		clr(6'h38);
		`CHK(o_no_ack_request, 1'b0)
		for (k = 0; k < 4; k++) begin
			i_format_select <= k[1];
			pulse(STOP_EV);
			if (k[0])
				pulse(ARB_EV);
			else
				pulse(NO_ACK_EV);
			`CHK(o_stop_seen_request, !k[1])
			`CHK(o_no_ack_request, !k[1])
			clr(6'h38);
			`CHK({o_stop_seen_request, o_no_ack_request}, 2'h0)
		end
		$display("event test done");
		i_master_mode <= 1'b1;
		for (k = 0; k < 8; k++) begin
			{i_clock_select_bit3, i_clock_select_bit2} <= k[1:0];
			stretch = k[2] ? 4'h6 : 4'h0;
			i_scl_drive_low <= 1'b1;
			repeat (20) @(posedge i_mclk);
			#1 `CHK({o_scl_oe, o_scl_out, o_scl_level}, 3'h4)
			@(posedge i_mclk) i_scl_drive_low <= 1'b0;
			n = 0;
			seen = 1'b0;
			while (o_scl_high_ok !== 1'b1 && n < 150) begin
				@(posedge i_mclk) #1 n++;
				seen = seen | (o_scl_stretching === 1'b1);
			end
			`CHK(n >= exp_mon(k[1:0]) && n < 150, 1'b1)
			`CHK(k[2] || n <= exp_mon(k[1:0]) + 2, 1'b1)
			`CHK(seen, k[2])
		end
		$display("clock sync test done");
		end_of_test();
	end
endmodule
